/* File: core/mse_pkg.sv */
// Package of constants and carrier types for the measurement sequencer engine
package mse_pkg;

    // Clock and internal timebase
    localparam int MCLK_HZ = 100000000;
    localparam int TICK_US = 1;                                  // Timebase step in us
    localparam int TICK_CYC = (MCLK_HZ / 1000000) * TICK_US;     // Cycles per us tick

    // Conversion times per 3-bit code, in us
    localparam logic [12:0] CT_US_0 = 13'h0032;   // 50
    localparam logic [12:0] CT_US_1 = 13'h0054;   // 84
    localparam logic [12:0] CT_US_2 = 13'h0096;   // 150
    localparam logic [12:0] CT_US_3 = 13'h0118;   // 280
    localparam logic [12:0] CT_US_4 = 13'h021c;   // 540
    localparam logic [12:0] CT_US_5 = 13'h041c;   // 1052
    localparam logic [12:0] CT_US_6 = 13'h081a;   // 2074
    localparam logic [12:0] CT_US_7 = 13'h1018;   // 4120

    // Start delay: one field step in us, field width 8 gives 0..510 ms
    localparam int DLY_STEP_MS = 2;
    localparam int DLY_STEP_US = DLY_STEP_MS * 1000;

    // Mode field positions: bit0 shunt, bit1 bus, bit2 temperature, bit3 continuous
    localparam int MODE_SHUNT_BIT = 0;
    localparam int MODE_BUS_BIT = 1;
    localparam int MODE_TEMP_BIT = 2;
    localparam int MODE_CONT_BIT = 3;
    localparam logic [3:0] MODE_RST = 4'hf;       // Continuous, all inputs

    // Reset values
    localparam logic [7:0] DLY_RST = 8'h00;
    localparam logic [2:0] AVG_RST = 3'h0;

    // Configuration carrier
    typedef struct packed {
        logic [2:0] ct_shunt;
        logic [2:0] ct_bus;
        logic [2:0] ct_temp;
        logic [2:0] avg_code;     // Averages = 4**code, 1 .. 16384 capped by parameter
        logic [7:0] start_delay_field;
        logic [15:0] shunt_cal;
    } mse_cfg_type;

    // Result carrier
    typedef struct packed {
        logic signed [19:0] current;
        logic [19:0] bus_volt;
        logic signed [15:0] temp;
        logic signed [39:0] power;
        logic signed [47:0] energy;
        logic signed [47:0] charge;
    } mse_res_type;

    // ADC sample carrier
    typedef struct packed {
        logic [1:0] chan;         // 0 shunt, 1 bus, 2 temperature
        logic signed [19:0] data;
    } mse_smp_type;

    localparam logic [1:0] CH_SHUNT = 2'h0;
    localparam logic [1:0] CH_BUS = 2'h1;
    localparam logic [1:0] CH_TEMP = 2'h2;

    // Sequencer states, Gray along idle-delay-convert-finish
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELAY = 3'b001,
        ST_CONV = 3'b011,
        ST_FINISH = 3'b010,
        ST_SHUT = 3'b110
    } mse_state_type;

endpackage

/* File: core/mse_engine.sv */
// Measurement sequencer: conversion order, averaging, derived quantities, ready flag, SPI MISO
//
// Function
// - Current and charge follow shunt samples; power and energy follow bus samples
// - Power uses latest computed current times newest bus voltage
// - Zero shunt calibration forces power, energy and charge to zero
// - Single-sample averaging loads results directly into output registers
// - Averaging sums samples per quantity, then averages, computes power, loads outputs
// - Energy and charge accumulate once per completed set, weighted by the last pass time
// - Calculations run beside conversions and never lengthen a pass
// - Mode field chooses any combination of shunt, bus and temperature
// - Each input has its own conversion-time code
// - Enabled inputs convert in turn; a pass lasts their summed times
// - Outputs hold until next complete set; reads never disturb conversions
// - Continuous mode repeats sequence and updates forever
// - Triggered mode runs one sequence, then shuts down until mode rewritten
// - Any mode write aborts conversion and restarts per new mode
// - Done flag sets only after all conversions and averaging finish
// - Done flag clears on alert register read or non-shutdown setup write
// - Triggered mode leaves energy and charge invalid; continuous needed
// - Programmable start delay, 0 to 510 ms in 2 ms steps, default zero
// - Serial side works with chip select held low permanently
// - Data output driven only while chip select low, released after rise
// - Conversion codes 0..7 map to 50..4120 us
`timescale 1ns/1ps
`default_nettype none

module mse_engine
    import mse_pkg::*;
#(
    parameter int MAX_AVG_CODE = 5          // Largest averaging code, 4**5 = 1024 samples
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Configuration from the register side
    input wire mse_cfg_type cfg,
    input wire logic [3:0] mode_wdata,
    input wire logic mode_wr,              // Write of the setup register, one cycle
    input wire logic alert_rd,             // Read of the diagnostic alert register, one cycle
    // ADC side: start a conversion, sample back when done
    output logic adc_start,
    output logic [1:0] adc_chan,
    input wire logic adc_valid,
    input wire mse_smp_type adc_sample,
    // Results and status
    output mse_res_type res,
    output logic res_update,
    output logic conversion_done_flag,
    output logic accum_valid,
    output logic busy,
    // Serial data output pin
    input wire logic cs_n_pin,
    input wire logic miso_bit,
    output logic miso_o,
    output logic miso_oe
);

    // Registered state
    mse_state_type state_r, state_nxt;
    logic [3:0] mode_r;
    logic [6:0] tick_cnt_r;
    logic [18:0] dly_us_r;
    logic [12:0] conv_us_r;
    logic [1:0] chan_r;
    logic [10:0] avg_cnt_r;
    logic signed [30:0] acc_cur_r;
    logic [30:0] acc_bus_r;
    logic signed [26:0] acc_tmp_r;
    logic signed [19:0] last_cur_r;
    logic [23:0] pass_us_r;
    logic done_r;
    logic accv_r;
    mse_res_type res_r;
    logic cs_s1_r, cs_s2_r;
    logic miso_r, oe_r;

    // Timebase: 1 us tick from mclk divider
    // All conversion, delay and pass counts run on this one tick, so they drift together
    wire tick = (tick_cnt_r == 7'(TICK_CYC - 1));

    // Conversion time lookup for a code
    function automatic logic [12:0] ct_lookup(input logic [2:0] code);
        case (code)
            3'h0: ct_lookup = CT_US_0;
            3'h1: ct_lookup = CT_US_1;
            3'h2: ct_lookup = CT_US_2;
            3'h3: ct_lookup = CT_US_3;
            3'h4: ct_lookup = CT_US_4;
            3'h5: ct_lookup = CT_US_5;
            3'h6: ct_lookup = CT_US_6;
            default: ct_lookup = CT_US_7;
        endcase
    endfunction

    // Enabled inputs and channel order
    wire en_sh = mode_r[MODE_SHUNT_BIT];
    wire en_bu = mode_r[MODE_BUS_BIT];
    wire en_te = mode_r[MODE_TEMP_BIT];
    wire cont = mode_r[MODE_CONT_BIT];
    wire any_en = en_sh | en_bu | en_te;
    wire shutdown_wr = mode_wr && (mode_wdata[2:0] == 3'h0);
    // First enabled channel of a pass, then next after the current one
    wire [1:0] first_ch = en_sh ? CH_SHUNT : (en_bu ? CH_BUS : CH_TEMP);
    wire has_next = (chan_r == CH_SHUNT) ? (en_bu | en_te) :
                    (chan_r == CH_BUS) ? en_te : 1'b0;
    wire [1:0] next_ch = (chan_r == CH_SHUNT && en_bu) ? CH_BUS : CH_TEMP;
    wire [2:0] ch_code = (chan_r == CH_SHUNT) ? cfg.ct_shunt :
                         (chan_r == CH_BUS) ? cfg.ct_bus : cfg.ct_temp;
    wire [12:0] ch_time = ct_lookup(ch_code);

    // Averaging target: 4**code samples, capped
    wire [2:0] avg_eff = (cfg.avg_code > 3'(MAX_AVG_CODE)) ? 3'(MAX_AVG_CODE) : cfg.avg_code;
    wire [10:0] avg_n = 11'h001 << {avg_eff, 1'b0};
    wire [4:0] avg_sh = {1'b0, avg_eff, 1'b0};
    wire last_avg = (avg_cnt_r == avg_n - 11'h001);

    // Conversion done on the timebase; the sample is expected with it
    wire conv_end = (state_r == ST_CONV) && tick && (conv_us_r == 13'h0001);
    wire pass_end = conv_end && !has_next;
    wire set_end = pass_end && last_avg;

    // Derived quantities; calibration gates power, energy and charge
    wire cal_zero = (cfg.shunt_cal == 16'h0000);
    wire signed [19:0] smp = adc_sample.data;
    wire signed [35:0] cur_full = smp * $signed({1'b0, cfg.shunt_cal});
    wire signed [19:0] cur_now = cur_full[35:16];
    wire signed [30:0] acc_cur_sum = acc_cur_r + 31'(cur_now);
    wire [30:0] acc_bus_sum = acc_bus_r + 31'(unsigned'(smp));
    // Temperature keeps its sign; a plain part-select would read negatives as large
    wire signed [26:0] acc_tmp_sum = acc_tmp_r + 27'(signed'(smp[19:4]));
    wire is_sh = adc_valid && (adc_sample.chan == CH_SHUNT);
    wire is_bu = adc_valid && (adc_sample.chan == CH_BUS);
    wire is_te = adc_valid && (adc_sample.chan == CH_TEMP);
    // Averaged results, right shift divides by 4**code, arithmetic for current and temperature, logical for bus
    wire signed [30:0] avg_cur = (is_sh ? acc_cur_sum : acc_cur_r) >>> avg_sh;
    wire [30:0] avg_bus = (is_bu ? acc_bus_sum : acc_bus_r) >> avg_sh;
    wire signed [26:0] avg_tmp = (is_te ? acc_tmp_sum : acc_tmp_r) >>> avg_sh;
    // Power from this set's current with the newest bus voltage; the held
    // current would lag one set behind
    wire signed [19:0] cur_for_pwr = en_sh ? avg_cur[19:0] : last_cur_r;
    wire signed [40:0] pwr_full = cur_for_pwr * $signed({1'b0, avg_bus[19:0]});
    wire signed [39:0] pwr_now = cal_zero ? 40'sh0 : pwr_full[39:0];
    // Energy and charge scaled by elapsed pass time in us
    // Limitation: with averaging they advance once per set, weighted by the last pass
    wire [23:0] pass_dur = pass_us_r + 24'h000001;
    wire signed [64:0] e_inc = pwr_now * $signed({1'b0, pass_dur});
    wire signed [44:0] q_inc = cur_for_pwr * $signed({1'b0, pass_dur});

    // Next state of the sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE, ST_SHUT: state_nxt = state_r;
            ST_DELAY: if (tick && dly_us_r <= 19'h00001) state_nxt = ST_CONV;
            ST_CONV: if (pass_end && (!last_avg || cont)) state_nxt = ST_CONV;
                     else if (pass_end) state_nxt = ST_FINISH;
            ST_FINISH: state_nxt = ST_SHUT;
            default: state_nxt = ST_IDLE;
        endcase
        if (mode_wr)
            state_nxt = (mode_wdata[2:0] == 3'h0) ? ST_SHUT : ST_DELAY;
    end

    // Timebase divider
    always_ff @(posedge mclk)
    begin
        if (!rstn || tick)
            tick_cnt_r <= 7'h00;
        else
            tick_cnt_r <= tick_cnt_r + 7'h01;
    end

    // Mode, state and delay counter; delay applies once per mode write
    // A write during the delay reloads it, so the newest setting always counts
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state_r <= ST_DELAY;
            mode_r <= MODE_RST;
            dly_us_r <= 19'h00000;
        end
        else
        begin
            state_r <= state_nxt;
            if (mode_wr)
            begin
                mode_r <= mode_wdata;
                dly_us_r <= 19'(cfg.start_delay_field * DLY_STEP_US);
            end
            else if (state_r == ST_DELAY && tick && dly_us_r != 19'h00000)
                dly_us_r <= dly_us_r - 19'h00001;
        end
    end

    // Channel walk and conversion timer; sums times of enabled inputs
    // A pass wraps to the first enabled input, so back-to-back passes leave no gap
    always_ff @(posedge mclk)
    begin
        if (!rstn || mode_wr)
        begin
            chan_r <= CH_SHUNT;
            conv_us_r <= 13'h0000;
            avg_cnt_r <= 11'h000;
            pass_us_r <= 24'h000000;
        end
        else if (state_r == ST_DELAY && state_nxt == ST_CONV)
        begin
            chan_r <= first_ch;
            conv_us_r <= ct_lookup(first_ch == CH_SHUNT ? cfg.ct_shunt :
                                   first_ch == CH_BUS ? cfg.ct_bus : cfg.ct_temp);
            avg_cnt_r <= 11'h000;
            pass_us_r <= 24'h000000;
        end
        else if (state_r == ST_CONV && tick)
        begin
            pass_us_r <= pass_end ? 24'h000000 : pass_us_r + 24'h000001;
            if (conv_end)
            begin
                chan_r <= has_next ? next_ch : first_ch;
                conv_us_r <= ct_lookup(has_next ? (next_ch == CH_BUS ? cfg.ct_bus : cfg.ct_temp)
                                       : (first_ch == CH_SHUNT ? cfg.ct_shunt :
                                          first_ch == CH_BUS ? cfg.ct_bus : cfg.ct_temp));
                if (pass_end)
                    avg_cnt_r <= last_avg ? 11'h000 : avg_cnt_r + 11'h001;
            end
            else
                conv_us_r <= conv_us_r - 13'h0001;
        end
    end

    // Averaging accumulators, cleared at each completed set
    always_ff @(posedge mclk)
    begin
        if (!rstn || mode_wr || set_end)
        begin
            acc_cur_r <= 31'sh0;
            acc_bus_r <= 31'h0;
            acc_tmp_r <= 27'sh0;
        end
        else
        begin
            if (is_sh) acc_cur_r <= acc_cur_sum;
            if (is_bu) acc_bus_r <= acc_bus_sum;
            if (is_te) acc_tmp_r <= acc_tmp_sum;
        end
    end

    // Output registers; arithmetic is single-cycle so passes never stretch
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            res_r <= '0;
            last_cur_r <= 20'sh0;
        end
        else if (set_end && !mode_wr)
        begin
            if (en_sh)
            begin
                res_r.current <= avg_cur[19:0];
                last_cur_r <= avg_cur[19:0];
                res_r.charge <= cal_zero ? 48'sh0 : res_r.charge + 48'(q_inc);
            end
            if (en_bu)
            begin
                res_r.bus_volt <= avg_bus[19:0];
                res_r.power <= pwr_now;
                res_r.energy <= cal_zero ? 48'sh0 : res_r.energy + 48'(e_inc);
            end
            if (en_te)
                res_r.temp <= avg_tmp[15:0];
            // Zero calibration shows at the next set, so outputs never jump between sets
            if (cal_zero)
            begin
                res_r.power <= 40'sh0;
                res_r.energy <= 48'sh0;
                res_r.charge <= 48'sh0;
            end
        end
    end

    // Ready flag: set beats alert read clear; accumulators valid only in continuous mode
    // A set and an alert read in one cycle leave it set; a mode write in that cycle drops the set
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            done_r <= 1'b0;
            accv_r <= MODE_RST[MODE_CONT_BIT];          // Reset mode is continuous
        end
        else
        begin
            if (set_end && !mode_wr)
                done_r <= 1'b1;
            else if (alert_rd || (mode_wr && !shutdown_wr))
                done_r <= 1'b0;
            if (mode_wr)
                accv_r <= mode_wdata[MODE_CONT_BIT] && (mode_wdata[2:0] != 3'h0);
        end
    end

    // Chip select synchroniser and data output driver
    // The pin is asynchronous; only the second stage feeds any logic
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else
        begin
            cs_s1_r <= cs_n_pin;
            cs_s2_r <= cs_s1_r;
            oe_r <= !cs_s2_r;
            miso_r <= cs_s2_r ? 1'b0 : miso_bit;
        end
    end

    // Outputs
    // A start marks the first tick of a channel; its sample must come on the last
    assign adc_start = (state_r == ST_CONV) && tick && (conv_us_r == ch_time) && any_en;
    assign adc_chan = chan_r;
    assign res = res_r;
    assign res_update = set_end && !mode_wr;
    assign conversion_done_flag = done_r;
    assign accum_valid = accv_r;
    assign busy = (state_r == ST_CONV) || (state_r == ST_DELAY);
    assign miso_o = miso_r;
    assign miso_oe = oe_r;

endmodule

`default_nettype wire

/* File: sim/mse_adc_model.sv */
// ADC partner model: answers each conversion start with a sample at the end tick
`timescale 1ns/1ps
`default_nettype none

module mse_adc_model
    import mse_pkg::*;
#(
    parameter logic [19:0] SMP_SHUNT = 20'h10000,
    parameter logic [19:0] SMP_BUS = 20'h00400,
    parameter logic [19:0] SMP_TEMP = 20'h00c80
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Control seen from the engine
    input wire mse_cfg_type cfg,
    input wire logic mode_wr,
    input wire logic adc_start,
    input wire logic [1:0] adc_chan,
    // Sample back to the engine
    output logic adc_valid,
    output mse_smp_type adc_sample
);
    logic act_r;
    logic [19:0] cnt_r;
    logic [1:0] chan_r;
    logic [2:0] code;
    logic [19:0] end_cyc;
    logic [19:0] data;

    function automatic logic [12:0] ct_us(input logic [2:0] c);
        case (c)
            3'h0: return CT_US_0;
            3'h1: return CT_US_1;
            3'h2: return CT_US_2;
            3'h3: return CT_US_3;
            3'h4: return CT_US_4;
            3'h5: return CT_US_5;
            3'h6: return CT_US_6;
            default: return CT_US_7;
        endcase
    endfunction

    // Each input has its own time code; the sample lands on the tick with 1 us left
    assign code = (chan_r == CH_SHUNT) ? cfg.ct_shunt : (chan_r == CH_BUS) ? cfg.ct_bus : cfg.ct_temp;
    assign end_cyc = 20'(ct_us(code)) * 20'(TICK_CYC) - 20'(TICK_CYC);
    assign adc_valid = act_r && (cnt_r == end_cyc);
    assign data = (chan_r == CH_SHUNT) ? SMP_SHUNT : (chan_r == CH_BUS) ? SMP_BUS : SMP_TEMP;
    // Outside the valid cycle the data churns, so a stale value never looks right
    assign adc_sample = adc_valid ? {chan_r, data} : {~chan_r, cnt_r};

    // Channel is taken one cycle after start, once the engine's register shows it
    always_ff @(posedge mclk)
    begin
        cnt_r <= adc_start ? 20'h00001 : cnt_r + 20'h00001;
        if (!rstn)
            act_r <= 1'b0;
        else if (adc_start)
            act_r <= 1'b1;
        else if (mode_wr || adc_valid)
            act_r <= 1'b0;
        if (act_r && cnt_r == 20'h00001)
            chan_r <= adc_chan;
    end
endmodule

`default_nettype wire

/* File: sim/mse_engine_asserts.sv */
// Checker of the sequencer engine port behaviour
`timescale 1ns/1ps
`default_nettype none

module mse_engine_asserts
    import mse_pkg::*;
#(
    parameter int MAX_AVG_CODE = 5
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire mse_cfg_type cfg,
    input wire logic [3:0] mode_wdata,
    input wire logic mode_wr,
    input wire logic alert_rd,
    input wire mse_res_type res,
    input wire logic res_update,
    input wire logic conversion_done_flag,
    input wire logic accum_valid,
    input wire logic busy,
    input wire logic cs_n_pin,
    input wire logic miso_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // ************************
    // Flag, results, modes
    // ************************
    property p_upd_flag; res_update |=> conversion_done_flag; endproperty
    a_upd_flag: assert property (p_upd_flag) else $error("flag not set by update");
    property p_flag_src; $rose(conversion_done_flag) |-> $past(res_update); endproperty
    a_flag_src: assert property (p_flag_src) else $error("flag set without update");
    property p_hold; !res_update |=> $stable(res); endproperty
    a_hold: assert property (p_hold) else $error("results changed without update");
    property p_clr_rd; alert_rd && !res_update |=> !conversion_done_flag; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("flag kept after alert read");
    property p_clr_wr;
        mode_wr && mode_wdata[2:0] != 3'h0 && !res_update |=> !conversion_done_flag;
    endproperty
    a_clr_wr: assert property (p_clr_wr) else $error("flag kept after setup write");
    property p_shut_keep;
        mode_wr && mode_wdata[2:0] == 3'h0 && !alert_rd && conversion_done_flag
            |=> conversion_done_flag;
    endproperty
    a_shut_keep: assert property (p_shut_keep) else $error("flag lost on shutdown");
    property p_busy; mode_wr && mode_wdata[2:0] != 3'h0 |=> busy; endproperty
    a_busy: assert property (p_busy) else $error("mode write did not start");
    property p_cal0;
        res_update && cfg.shunt_cal == 16'h0000 |=> res.power == 40'h0 && res.energy == 48'h0
            && res.charge == 48'h0;
    endproperty
    a_cal0: assert property (p_cal0) else $error("derived nonzero with zero cal");
    property p_trig_acc; mode_wr && !mode_wdata[3] |=> !accum_valid; endproperty
    a_trig_acc: assert property (p_trig_acc) else $error("accum valid in triggered");

    // ************************
    // Serial output enable
    // ************************
    property p_oe_on; (!cs_n_pin)[*5] |-> miso_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not driven while selected");
    property p_oe_off; cs_n_pin[*5] |-> !miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
endmodule

bind mse_engine mse_engine_asserts #(.MAX_AVG_CODE(MAX_AVG_CODE)) u_chk (.mclk(mclk),
    .rstn(rstn), .cfg(cfg), .mode_wdata(mode_wdata), .mode_wr(mode_wr), .alert_rd(alert_rd),
    .res(res), .res_update(res_update), .conversion_done_flag(conversion_done_flag),
    .accum_valid(accum_valid), .busy(busy), .cs_n_pin(cs_n_pin), .miso_oe(miso_oe));

`default_nettype wire

/* File: sim/tb_measurement_sequencer_engine.sv */
// Self-checking testbench of the sequencer engine
`timescale 1ns/1ps
`default_nettype none

module tb_measurement_sequencer_engine
    import mse_pkg::*;
;
    typedef struct packed {logic [3:0] mode; logic [2:0] ctb; logic [15:0] us;} mse_row_type;
    mse_row_type rows [5] = '{'{4'h1, 3'h0, 16'h0032}, '{4'h2, 3'h1, 16'h0054},
        '{4'h4, 3'h0, 16'h0032}, '{4'h3, 3'h0, 16'h0064}, '{4'h7, 3'h0, 16'h0096}};
    logic mclk, rstn, mode_wr, alert_rd, adc_start, adc_valid, res_update, conversion_done_flag;
    logic accum_valid, busy, cs_n_pin, miso_bit, miso_o, miso_oe, start_d;
    logic [3:0] mode_wdata;
    logic [1:0] adc_chan;
    logic [8:0] ord;
    logic [47:0] q0;
    mse_cfg_type cfg;
    mse_smp_type adc_sample;
    mse_res_type res;
    int err_count, n_tests, c, n_starts;

    mse_engine #(.MAX_AVG_CODE(5)) uut (.mclk(mclk), .rstn(rstn), .cfg(cfg),
        .mode_wdata(mode_wdata), .mode_wr(mode_wr), .alert_rd(alert_rd), .adc_start(adc_start),
        .adc_chan(adc_chan), .adc_valid(adc_valid), .adc_sample(adc_sample), .res(res),
        .res_update(res_update), .conversion_done_flag(conversion_done_flag),
        .accum_valid(accum_valid), .busy(busy), .cs_n_pin(cs_n_pin), .miso_bit(miso_bit),
        .miso_o(miso_o), .miso_oe(miso_oe));
    mse_adc_model u_adc (.mclk(mclk), .rstn(rstn), .cfg(cfg), .mode_wr(mode_wr),
        .adc_start(adc_start), .adc_chan(adc_chan), .adc_valid(adc_valid),
        .adc_sample(adc_sample));

    always #5 mclk = ~mclk;

    // Channel order is logged a cycle after each start, when the channel register holds
    always @(posedge mclk)
    begin
        start_d <= adc_start;
        if (adc_start)
            n_starts <= n_starts + 1;
        if (start_d)
            ord <= {ord[5:0], 1'b1, adc_chan};
    end

    function automatic logic [8:0] exp_ord(input logic [3:0] m);
        logic [8:0] o;
        o = 9'h000;
        for (int k = 0; k < 3; k++)
            if (m[k])
                o = {o[5:0], 1'b1, 2'(k)};
        return o;
    endfunction

    task automatic final_report();
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    // Cycle counts carry 250 cycles, two and a half ticks, of alignment slack at either end
    task automatic chk_rng(input string name, input int e, input int g);
        n_tests++;
        if (g < e - 250 || g > e + 250)
        begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", name, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] m);
        @(posedge mclk);
        mode_wdata <= m;
        mode_wr <= 1'b1;
        @(posedge mclk);
        mode_wr <= 1'b0;
        @(negedge mclk);
        ord = 9'h000;
    endtask

    task automatic rd_alert();
        @(posedge mclk);
        alert_rd <= 1'b1;
        @(posedge mclk);
        alert_rd <= 1'b0;
        @(negedge mclk);
    endtask

    // Returns once the loaded results are visible
    task automatic wait_upd(output int cyc);
        cyc = 0;
        while (res_update !== 1'b1)
        begin
            @(negedge mclk);
            cyc++;
            if (cyc > 25000)
            begin
                err_count++;
                $display("BAD res_update expected 1 seen timeout");
                final_report();
            end
        end
        @(negedge mclk);
    endtask

    initial
    begin
        mclk = 1'b0;
        rstn = 1'b0;
        cfg = '0;
        cfg.shunt_cal = 16'h0100;
        mode_wdata = 4'h0;
        mode_wr = 1'b0;
        alert_rd = 1'b0;
        cs_n_pin = 1'b1;
        miso_bit = 1'b0;
        ord = 9'h000;
        start_d = 1'b0;
        n_starts = 0;
        err_count = 0;
        n_tests = 0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("res_rst", 48'h0, 48'(res.energy | res.charge));
        chk("flag_rst", 48'h0, 48'(conversion_done_flag));
        chk("oe_rst", 48'h0, 48'(miso_oe));
        @(posedge mclk);
        rstn <= 1'b1;
        // ************************
        // Triggered passes per mode
        // ************************
        foreach (rows[i])
        begin
            @(posedge mclk);
            cfg.ct_bus <= rows[i].ctb;
            wr(rows[i].mode);
            wait_upd(c);
            chk_rng("pass_cycles", int'(rows[i].us) * 100, c);
            chk("order", 48'(exp_ord(rows[i].mode)), 48'(ord));
            chk("done_flag", 48'h1, 48'(conversion_done_flag));
            if (rows[i].mode[0])
                chk("current", 48'h100, 48'(res.current));
            if (rows[i].mode[1])
                chk("bus_volt", 48'h400, 48'(res.bus_volt));
            if (rows[i].mode[1])
                chk("power", 48'h40000, 48'(res.power));
            if (rows[i].mode[2])
                chk("temp", 48'hc8, 48'(res.temp));
            n_starts = 0;
            repeat (300) @(negedge mclk);
            chk("starts_shut", 48'h0, 48'(n_starts));
            chk("busy_shut", 48'h0, 48'(busy));
            rd_alert();
            chk("flag_rd", 48'h0, 48'(conversion_done_flag));
        end
        // ************************
        // Awkward cases
        // ************************
        @(posedge mclk);
        cfg.avg_code <= 3'h1;
        wr(4'h1);
        wait_upd(c);
        chk_rng("avg_cycles", 20000, c);
        chk("avg_current", 48'h100, 48'(res.current));
        @(posedge mclk);
        cfg.avg_code <= 3'h0;
        wr(4'h9);
        wait_upd(c);
        q0 = res.charge;
        wait_upd(c);
        chk_rng("cont_cycles", 5000, c);
        chk("charge_step", 48'h3200, res.charge - q0);
        chk("accum_valid", 48'h1, 48'(accum_valid));
        repeat (2000) @(negedge mclk);
        wr(4'h2);
        wait_upd(c);
        chk_rng("abort_cycles", 5000, c);
        chk("abort_order", 48'(exp_ord(4'h2)), 48'(ord));
        wr(4'h0);
        chk("flag_shutdown", 48'h1, 48'(conversion_done_flag));
        chk("busy_shutdown", 48'h0, 48'(busy));
        wr(4'h1);
        chk("flag_setup_wr", 48'h0, 48'(conversion_done_flag));
        wait_upd(c);
        @(posedge mclk);
        cfg.shunt_cal <= 16'h0000;
        wr(4'h3);
        wait_upd(c);
        chk("power_cal0", 48'h0, 48'(res.power));
        chk("energy_charge_cal0", 48'h0, res.energy | res.charge);
        @(posedge mclk);
        cs_n_pin <= 1'b0;
        miso_bit <= 1'b1;
        repeat (6) @(negedge mclk);
        chk("oe_selected", 48'h1, 48'(miso_oe));
        chk("miso_high", 48'h1, 48'(miso_o));
        repeat (50) @(negedge mclk);
        @(posedge mclk);
        miso_bit <= 1'b0;
        repeat (4) @(negedge mclk);
        chk("oe_held_low", 48'h1, 48'(miso_oe));
        chk("miso_low", 48'h0, 48'(miso_o));
        @(posedge mclk);
        cs_n_pin <= 1'b1;
        repeat (6) @(negedge mclk);
        chk("oe_released", 48'h0, 48'(miso_oe));
        final_report();
    end
endmodule

`default_nettype wire
